// file: logic/ldio_pkg.sv
// Constants and types shared by the logical device I/O decoder
package ldio_pkg;
  // **********************************************************
  // Configuration port and register indices
  // **********************************************************
  localparam logic [15:0] LDIO_CFG_INDEX_PORT = 16'h002E;
  localparam logic [15:0] LDIO_CFG_DATA_PORT  = 16'h002F;
  localparam logic [7:0]  LDIO_IDX_LDN        = 8'h07;
  localparam logic [7:0]  LDIO_IDX_PWR        = 8'h22;
  localparam logic [7:0]  LDIO_IDX_GCFG       = 8'h24;
  localparam int          LDIO_GCFG_A16_BIT   = 6;
  localparam logic [7:0]  LDIO_IDX_ACT        = 8'h30;
  localparam logic [7:0]  LDIO_IDX_BASE_HI    = 8'h60;
  localparam logic [7:0]  LDIO_IDX_BASE_LO    = 8'h61;
  localparam logic [7:0]  LDIO_IDX_IRQ        = 8'h70;
  localparam logic [7:0]  LDIO_IDX_DMA        = 8'h74;

  // **********************************************************
  // Logical device numbers
  // **********************************************************
  localparam int LDIO_NUM_DEV       = 8;
  localparam int LDIO_LDN_FLOPPY    = 0;
  localparam int LDIO_LDN_PARALLEL  = 3;
  localparam int LDIO_LDN_SERIAL1   = 4;
  localparam int LDIO_LDN_SERIAL2   = 5;
  localparam int LDIO_LDN_KEYBOARD  = 7;

  // **********************************************************
  // Base ranges, alignments and fixed ports
  // **********************************************************
  localparam logic [11:0] LDIO_BASE_MIN      = 12'h100;
  localparam logic [11:0] LDIO_BASE_MAX8     = 12'hFF8;
  localparam logic [11:0] LDIO_BASE_MAX4     = 12'hFFC;
  localparam logic [11:0] LDIO_ALIGN8        = 12'h007;
  localparam logic [11:0] LDIO_ALIGN4        = 12'h003;
  localparam logic [11:0] LDIO_KBD_DATA_PORT = 12'h060;
  localparam logic [11:0] LDIO_KBD_CMD_PORT  = 12'h064;
  localparam logic [2:0]  LDIO_FLOPPY_HOLE   = 3'h6;
  localparam logic [2:0]  LDIO_EPP_FIRST     = 3'h3;

  // **********************************************************
  // Reset values
  // **********************************************************
  localparam logic [7:0]  LDIO_IRQ_RST_FLOPPY   = 8'h06;
  localparam logic [7:0]  LDIO_IRQ_RST_DEFAULT  = 8'h00;
  localparam logic [7:0]  LDIO_DMA_RST_FLOPPY   = 8'h02;
  localparam logic [7:0]  LDIO_DMA_RST_PARALLEL = 8'h04;
  localparam logic [7:0]  LDIO_DMA_RST_DEFAULT  = 8'h00;
  localparam logic [15:0] LDIO_BASE_RST         = 16'h0000;
  localparam logic [7:0]  LDIO_REG_RST          = 8'h00;

  typedef logic [2:0] ldio_dev_t;
endpackage : ldio_pkg

// file: logic/ldio_base_window.sv
// Range, alignment and address match for one relocatable unit
`timescale 1ns/1ps
`default_nettype none
module ldio_base_window (
  input  wire logic [15:0] base,
  input  wire logic [15:0] addr,
  input  wire logic        a16_en,
  input  wire logic [11:0] max_base,
  input  wire logic [11:0] align,
  input  wire logic [11:0] win,
  output logic             base_ok,
  output logic             hit,
  output logic [2:0]       offset
);
  import ldio_pkg::*;

  // **********************************************************
  // Base legality
  // **********************************************************
  logic top_zero;
  logic in_range;
  logic aligned;
  logic addr_top_ok;
  logic addr_match;

  // Base must sit inside the window and on its boundary
  assign top_zero = (base[15:12] == 4'h0);
  assign in_range = (base[11:0] >= LDIO_BASE_MIN) &&
                    (base[11:0] <= max_base);
  assign aligned  = ((base[11:0] & align) == 12'h000);
  assign base_ok  = top_zero && in_range && aligned;

  // **********************************************************
  // Address match
  // **********************************************************
  // Upper bits qualified only when 16-bit decode is on
  assign addr_top_ok = !a16_en || (addr[15:12] == 4'h0);
  assign addr_match  = ((addr[11:0] & ~win) == (base[11:0] & ~win));
  assign hit         = base_ok && addr_top_ok && addr_match;
  assign offset      = addr[2:0] & win[2:0];
endmodule // ldio_base_window
`default_nettype wire

// file: logic/ldio_decoder.sv
// Logical device configuration registers and I/O decode
// Function
// (R01) Activate and power bits written together
// (R02) Out-of-range base ignores host accesses
// (R03) Floppy interrupt select resets to 0x06
// (R04) DMA select resets 0x02 floppy, 0x04 parallel
// (R05) Parallel base 4/8 aligned; EPP needs 8
// (R06) Serial base 8-aligned, offsets 0 to 7
// (R07) Keyboard fixed at ports 60 and 64
// (R08) Floppy base 8-aligned, offset 6 skipped
// (R09) Device on when activate or power set
// (R10) Index 0x60 high byte, 0x61 low byte
// (R11) Decode A11-A0; A15-A12 zero when enabled
`timescale 1ns/1ps
`default_nettype none
module ldio_decoder (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  output logic [7:0]       cfg_rdata,
  output logic             cfg_rvalid,
  output logic             floppy_unit_sel,
  output logic             parallel_sel,
  output logic [1:0]       serial_sel,
  output logic             keyboard_controller_unit_sel,
  output logic [2:0]       unit_offset,
  output logic             unit_wr,
  output logic             unit_rd,
  output logic [7:0]       unit_wdata,
  output logic [7:0]       device_on,
  output logic [31:0]      irq_sel_flat,
  output logic [2:0]       floppy_dma_sel,
  output logic [2:0]       parallel_dma_sel
);
  import ldio_pkg::*;

  // **********************************************************
  // Storage
  // **********************************************************
  logic [7:0]  cfg_index;
  logic [7:0]  ldn;
  logic [7:0]  gcfg;
  logic [7:0]  act_q;
  logic [7:0]  pwr_q;
  logic [15:0] base_q [LDIO_NUM_DEV];
  logic [7:0]  irq_q  [LDIO_NUM_DEV];
  logic [7:0]  dma_q  [LDIO_NUM_DEV];

  // Which devices own base and DMA registers
  function automatic logic has_base(input int d);
    return (d == LDIO_LDN_FLOPPY) || (d == LDIO_LDN_PARALLEL) ||
           (d == LDIO_LDN_SERIAL1) || (d == LDIO_LDN_SERIAL2);
  endfunction

  function automatic logic has_dma(input int d);
    return (d == LDIO_LDN_FLOPPY) || (d == LDIO_LDN_PARALLEL);
  endfunction

  // **********************************************************
  // Configuration port decode
  // **********************************************************
  logic      idx_hit;
  logic      data_hit;
  logic      wr_index;
  logic      wr_data;
  logic      ldn_ok;
  ldio_dev_t sel_dev;
  logic      wr_pwr;
  logic      a16_en;

  assign idx_hit  = (io_addr == LDIO_CFG_INDEX_PORT);
  assign data_hit = (io_addr == LDIO_CFG_DATA_PORT);
  assign wr_index = io_wr && idx_hit;
  assign wr_data  = io_wr && data_hit;
  assign ldn_ok   = (ldn[7:3] == 5'h00);
  assign sel_dev  = ldn[2:0];
  assign wr_pwr   = wr_data && (cfg_index == LDIO_IDX_PWR);
  assign a16_en   = gcfg[LDIO_GCFG_A16_BIT];

  // Index, device number and global configuration
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_index <= LDIO_REG_RST;
      ldn       <= LDIO_REG_RST;
      gcfg      <= LDIO_REG_RST;
    end else begin
      if (wr_index)
        cfg_index <= io_wdata;
      if (wr_data && (cfg_index == LDIO_IDX_LDN))
        ldn <= io_wdata;
      if (wr_data && (cfg_index == LDIO_IDX_GCFG))
        gcfg <= io_wdata;
    end
  end

  // **********************************************************
  // Per-device registers
  // **********************************************************
  genvar gi;
  generate
    for (gi = 0; gi < LDIO_NUM_DEV; gi++) begin : g_dev
      logic dev_wr;

      assign dev_wr = wr_data && ldn_ok && (sel_dev == gi);

      // Activate and power bits always written as a pair
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          act_q[gi] <= 1'b0;
          pwr_q[gi] <= 1'b0;
        end else if (dev_wr && (cfg_index == LDIO_IDX_ACT)) begin
          act_q[gi] <= io_wdata[0]; // R01
          pwr_q[gi] <= io_wdata[0]; // R01
        end else if (wr_pwr) begin
          act_q[gi] <= io_wdata[gi]; // R01
          pwr_q[gi] <= io_wdata[gi]; // R01
        end
      end

      // Base, interrupt and DMA selection
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          base_q[gi] <= LDIO_BASE_RST;
          irq_q[gi]  <= (gi == LDIO_LDN_FLOPPY) ? LDIO_IRQ_RST_FLOPPY
                                                : LDIO_IRQ_RST_DEFAULT; // R03
          dma_q[gi]  <= (gi == LDIO_LDN_FLOPPY)   ? LDIO_DMA_RST_FLOPPY :
                        (gi == LDIO_LDN_PARALLEL) ? LDIO_DMA_RST_PARALLEL
                                                  : LDIO_DMA_RST_DEFAULT; // R04
        end else if (dev_wr) begin
          if (has_base(gi) && (cfg_index == LDIO_IDX_BASE_HI))
            base_q[gi][15:8] <= io_wdata; // R10
          if (has_base(gi) && (cfg_index == LDIO_IDX_BASE_LO))
            base_q[gi][7:0] <= io_wdata; // R10
          if (cfg_index == LDIO_IDX_IRQ)
            irq_q[gi] <= io_wdata;
          if (has_dma(gi) && (cfg_index == LDIO_IDX_DMA))
            dma_q[gi] <= io_wdata;
        end
      end

      assign device_on[gi] = act_q[gi] || pwr_q[gi]; // R09
      assign irq_sel_flat[gi*4 +: 4] = irq_q[gi][3:0];
    end
  endgenerate

  assign floppy_dma_sel   = dma_q[LDIO_LDN_FLOPPY][2:0];
  assign parallel_dma_sel = dma_q[LDIO_LDN_PARALLEL][2:0];

  // **********************************************************
  // Configuration read
  // **********************************************************
  logic [7:0] dev_rd;
  logic [7:0] data_rd;
  logic [7:0] next_cfg_rdata;

  // Unused locations read as zero
  assign dev_rd =
    !ldn_ok                          ? 8'h00 :
    (cfg_index == LDIO_IDX_ACT)      ? {7'h00, act_q[sel_dev]} :
    (cfg_index == LDIO_IDX_BASE_HI)  ? base_q[sel_dev][15:8] :
    (cfg_index == LDIO_IDX_BASE_LO)  ? base_q[sel_dev][7:0] :
    (cfg_index == LDIO_IDX_IRQ)      ? irq_q[sel_dev] :
    (cfg_index == LDIO_IDX_DMA)      ? dma_q[sel_dev] : 8'h00;
  assign data_rd =
    (cfg_index == LDIO_IDX_LDN)  ? ldn :
    (cfg_index == LDIO_IDX_PWR)  ? pwr_q :
    (cfg_index == LDIO_IDX_GCFG) ? gcfg : dev_rd;
  assign next_cfg_rdata = idx_hit ? cfg_index : data_rd;

  // Read data registered one cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_rdata  <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= io_rd && (idx_hit || data_hit);
      if (io_rd && (idx_hit || data_hit))
        cfg_rdata <= next_cfg_rdata;
    end
  end

  // **********************************************************
  // Unit address decode
  // **********************************************************
  logic       flp_ok, flp_win, par_ok, par_win, par_epp, par_hit;
  logic       flp_hit, kbd_hit, a16_ok, cfg_hit, strobe;
  logic [2:0] par_off;
  logic [1:0] ser_ok, ser_hit;

  assign strobe  = io_wr || io_rd;
  assign cfg_hit = idx_hit || data_hit;
  assign a16_ok  = !a16_en || (io_addr[15:12] == 4'h0); // R11

  ldio_base_window u_floppy (
    .base     (base_q[LDIO_LDN_FLOPPY]),
    .addr     (io_addr),
    .a16_en   (a16_en),
    .max_base (LDIO_BASE_MAX8),
    .align    (LDIO_ALIGN8),
    .win      (LDIO_ALIGN8),
    .base_ok  (flp_ok),
    .hit      (flp_win),
    .offset   ()
  );
  // Floppy skips offset 6 and needs power and a legal base
  assign flp_hit = flp_win && device_on[LDIO_LDN_FLOPPY] &&
                   (io_addr[2:0] != LDIO_FLOPPY_HOLE); // R08 R02

  // EPP window only when base is on an 8-byte boundary
  assign par_epp = (base_q[LDIO_LDN_PARALLEL][2] == 1'b0); // R05
  ldio_base_window u_parallel (
    .base     (base_q[LDIO_LDN_PARALLEL]),
    .addr     (io_addr),
    .a16_en   (a16_en),
    .max_base (LDIO_BASE_MAX4),
    .align    (LDIO_ALIGN4),
    .win      (par_epp ? LDIO_ALIGN8 : LDIO_ALIGN4),
    .base_ok  (par_ok),
    .hit      (par_win),
    .offset   (par_off)
  );
  assign par_hit = par_win && device_on[LDIO_LDN_PARALLEL] &&
                   (par_epp || (par_off < LDIO_EPP_FIRST)); // R05 R02

  // Two serial ports share one decode shape
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ser
      logic win_hit;
      ldio_base_window u_serial (
        .base     (base_q[LDIO_LDN_SERIAL1 + gi]),
        .addr     (io_addr),
        .a16_en   (a16_en),
        .max_base (LDIO_BASE_MAX8),
        .align    (LDIO_ALIGN8),
        .win      (LDIO_ALIGN8),
        .base_ok  (ser_ok[gi]),
        .hit      (win_hit),
        .offset   ()
      );
      assign ser_hit[gi] = win_hit &&
                           device_on[LDIO_LDN_SERIAL1 + gi]; // R06 R02
    end
  endgenerate

  // Keyboard sits at fixed ports, no base involved
  assign kbd_hit = device_on[LDIO_LDN_KEYBOARD] && a16_ok &&
                   ((io_addr[11:0] == LDIO_KBD_DATA_PORT) ||
                    (io_addr[11:0] == LDIO_KBD_CMD_PORT)); // R07

  // One-hot selection by fixed priority
  logic       next_kbd, next_flp, next_par;
  logic [1:0] next_ser;
  logic [2:0] next_off;
  assign next_kbd = strobe && !cfg_hit && kbd_hit;
  assign next_flp = strobe && !cfg_hit && !kbd_hit && flp_hit;
  assign next_par = strobe && !cfg_hit && !kbd_hit && !flp_hit && par_hit;
  assign next_ser[0] = strobe && !cfg_hit && !kbd_hit && !flp_hit &&
                       !par_hit && ser_hit[0];
  assign next_ser[1] = strobe && !cfg_hit && !kbd_hit && !flp_hit &&
                       !par_hit && !ser_hit[0] && ser_hit[1];
  assign next_off = next_par ? par_off : io_addr[2:0];

  // Unit strobes registered one cycle after the host strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      keyboard_controller_unit_sel <= 1'b0;
      floppy_unit_sel <= 1'b0;
      parallel_sel    <= 1'b0;
      serial_sel      <= 2'h0;
      unit_offset     <= 3'h0;
      unit_wr         <= 1'b0;
      unit_rd         <= 1'b0;
      unit_wdata      <= 8'h00;
    end else begin
      keyboard_controller_unit_sel <= next_kbd;
      floppy_unit_sel <= next_flp;
      parallel_sel    <= next_par;
      serial_sel      <= next_ser;
      unit_wr <= io_wr && (next_kbd || next_flp || next_par || |next_ser);
      unit_rd <= io_rd && (next_kbd || next_flp || next_par || |next_ser);
      if (strobe) begin
        unit_offset <= next_off;
        unit_wdata  <= io_wdata;
      end
    end
  end

  // **********************************************************
  // Assertions
  // **********************************************************
  property p_link;
    @(posedge ref_clk) disable iff (rst)
    (wr_data && ldn_ok && (cfg_index == LDIO_IDX_ACT))
    |=> (act_q[$past(sel_dev)] == $past(io_wdata[0])) && (pwr_q == act_q);
  endproperty
  a_link: assert property (p_link) else $error("activate/power split"); // R01

  property p_bad_base;
    @(posedge ref_clk) disable iff (rst)
    (strobe && !flp_ok && !par_ok && (ser_ok == 2'h0) && !kbd_hit)
    |=> !floppy_unit_sel && !parallel_sel && (serial_sel == 2'h0);
  endproperty
  a_bad_base: assert property (p_bad_base) else $error("bad base decoded"); // R02

  property p_irq_rst;
    @(posedge ref_clk) disable iff (rst)
    $past(rst) |-> (irq_q[0] == LDIO_IRQ_RST_FLOPPY) &&
                   (irq_q[1] == LDIO_IRQ_RST_DEFAULT);
  endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq reset wrong"); // R03

  property p_dma_rst;
    @(posedge ref_clk) disable iff (rst)
    $past(rst) |-> (dma_q[0] == LDIO_DMA_RST_FLOPPY) &&
                   (dma_q[3] == LDIO_DMA_RST_PARALLEL);
  endproperty
  a_dma_rst: assert property (p_dma_rst) else $error("dma reset wrong"); // R04

  property p_epp;
    @(posedge ref_clk) disable iff (rst)
    (parallel_sel && (unit_offset >= LDIO_EPP_FIRST))
    |-> !$past(base_q[LDIO_LDN_PARALLEL][2]);
  endproperty
  a_epp: assert property (p_epp) else $error("EPP on 4-byte base"); // R05

  property p_serial;
    @(posedge ref_clk) disable iff (rst)
    next_ser[0] |=> serial_sel[0] && unit_offset == $past(io_addr[2:0]);
  endproperty
  a_serial: assert property (p_serial) else $error("serial decode"); // R06

  property p_kbd;
    @(posedge ref_clk) disable iff (rst)
    (strobe && device_on[LDIO_LDN_KEYBOARD] && !a16_en &&
     (io_addr[11:0] == LDIO_KBD_CMD_PORT))
    |=> keyboard_controller_unit_sel && (unit_offset == 3'h4);
  endproperty
  a_kbd: assert property (p_kbd) else $error("keyboard port missed"); // R07

  property p_flp_hole;
    @(posedge ref_clk) disable iff (rst)
    floppy_unit_sel |-> (unit_offset != LDIO_FLOPPY_HOLE) && $past(flp_ok);
  endproperty
  a_flp_hole: assert property (p_flp_hole) else $error("floppy +6"); // R08

  property p_on;
    @(posedge ref_clk) disable iff (rst)
    wr_pwr |=> (device_on == $past(io_wdata));
  endproperty
  a_on: assert property (p_on) else $error("device not on"); // R09

  property p_base_lo;
    @(posedge ref_clk) disable iff (rst)
    (wr_data && ldn == 8'h04 && cfg_index == LDIO_IDX_BASE_LO)
    |=> base_q[4][7:0] == $past(io_wdata) && $stable(base_q[4][15:8]);
  endproperty
  a_base_lo: assert property (p_base_lo) else $error("base low wrong"); // R10

  property p_a16;
    @(posedge ref_clk) disable iff (rst)
    (strobe && a16_en && (io_addr[15:12] != 4'h0))
    |=> !unit_wr && !unit_rd;
  endproperty
  a_a16: assert property (p_a16) else $error("A15-A12 not qualified"); // R11

  c_cfg_read: cover property (@(posedge ref_clk) disable iff (rst)
    cfg_rvalid);
  c_epp: cover property (@(posedge ref_clk) disable iff (rst)
    parallel_sel && unit_offset == 3'h5);
  c_serial2: cover property (@(posedge ref_clk) disable iff (rst)
    serial_sel[1] && unit_wr);
  c_kbd: cover property (@(posedge ref_clk) disable iff (rst)
    keyboard_controller_unit_sel && unit_rd);
endmodule // ldio_decoder
`default_nettype wire

// file: tb/ldio_host_model.sv
// Host chipset model issuing one-cycle I/O strobes
`timescale 1ns/1ps
`default_nettype none
module ldio_host_model (
  input  wire logic        ref_clk,
  output logic [15:0]      io_addr,
  output logic [7:0]       io_wdata,
  output logic             io_wr,
  output logic             io_rd
);
  // Quiet bus at time zero
  initial begin
    io_addr  = 16'h0000;
    io_wdata = 8'h00;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
  end

  // One strobe cycle, launched and ended at falling edges
  task automatic cycle(input logic wr, input logic rd,
                       input logic [15:0] a, input logic [7:0] d);
    io_wr    = wr;
    io_rd    = rd;
    io_addr  = a;
    io_wdata = d;
    @(negedge ref_clk);
  endtask

  // Released bus shows inverted junk, never the last value
  task automatic idle();
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_addr  = ~io_addr;
    io_wdata = ~io_wdata;
    @(negedge ref_clk);
  endtask
endmodule // ldio_host_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the logical device I/O decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ldio_pkg::*;
  logic        ref_clk;
  logic        rst;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  cfg_rdata;
  logic        cfg_rvalid;
  logic        floppy_unit_sel;
  logic        parallel_sel;
  logic [1:0]  serial_sel;
  logic        keyboard_controller_unit_sel;
  logic [2:0]  unit_offset;
  logic        unit_wr;
  logic        unit_rd;
  logic [7:0]  unit_wdata;
  logic [7:0]  device_on;
  logic [31:0] irq_sel_flat;
  logic [2:0]  floppy_dma_sel;
  logic [2:0]  parallel_dma_sel;
  logic [7:0]  got_sel;
  // ****************************************
  // Reference model state
  // ****************************************
  logic [7:0]  act_v;
  logic [7:0]  ldn;
  logic [7:0]  idx;
  logic [7:0]  gcfg;
  logic [15:0] bas [8];
  logic [7:0]  irq [8];
  logic [7:0]  dma [8];
  logic [31:0] seed;
  int          miscompares;
  int          check_count;
  int          cycles;
  int          order [4] = '{0, 3, 4, 5};
  logic [4:0]  sbit [4] = '{5'h08, 5'h04, 5'h01, 5'h02};
  int          tdev [11] = '{0, 3, 3, 4, 5, 4, 4, 5, 3, 3, 0};
  logic [15:0] tbase [11] = '{16'h03F0, 16'h0378, 16'h0104, 16'h0FF8,
    16'h0100, 16'h00F8, 16'h0FFC, 16'h1100, 16'h0FFC, 16'h0102, 16'h03F4};
  logic [15:0] kaddr [5] = '{16'h0060, 16'h0064, 16'h0061, 16'h1064,
    16'h0065};

  // Clock and unit select collection
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;
  assign got_sel = {3'h0, keyboard_controller_unit_sel, floppy_unit_sel,
                    parallel_sel, serial_sel};

  ldio_host_model host (.ref_clk(ref_clk), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd));

  ldio_decoder dut (.ref_clk(ref_clk), .rst(rst), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .floppy_unit_sel(floppy_unit_sel), .parallel_sel(parallel_sel),
    .serial_sel(serial_sel),
    .keyboard_controller_unit_sel(keyboard_controller_unit_sel),
    .unit_offset(unit_offset), .unit_wr(unit_wr), .unit_rd(unit_rd),
    .unit_wdata(unit_wdata), .device_on(device_on),
    .irq_sel_flat(irq_sel_flat), .floppy_dma_sel(floppy_dma_sel),
    .parallel_dma_sel(parallel_dma_sel));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected {kbd, floppy, parallel, serial2, serial1, offset}
  function automatic logic [7:0] dec(input logic [15:0] a);
    logic [11:0] o;
    logic [11:0] b;
    logic        ok;
    int          d;
    if (a == LDIO_CFG_INDEX_PORT || a == LDIO_CFG_DATA_PORT)
      return 8'h00;
    if (gcfg[LDIO_GCFG_A16_BIT] && a[15:12] != 4'h0)
      return 8'h00;
    if (act_v[7] && (a[11:0] == 12'h060 || a[11:0] == 12'h064))
      return {5'h10, a[2:0]};
    for (int i = 0; i < 4; i++) begin
      d = order[i];
      b = bas[d][11:0];
      o = a[11:0] - b;
      ok = bas[d][15:12] == 4'h0 && b >= LDIO_BASE_MIN;
      if (d == 3)
        ok = ok && b <= LDIO_BASE_MAX4 && b[1:0] == 2'h0
             && o < (b[2] ? 12'h003 : 12'h008);
      else
        ok = ok && b <= LDIO_BASE_MAX8 && b[2:0] == 3'h0 && o < 12'h008
             && !(d == 0 && o == 12'h006);
      if (act_v[d] && ok)
        return {sbit[i], o[2:0]};
    end
    return 8'h00;
  endfunction

  // Expected read data of the selected index
  function automatic logic [7:0] cfg_rd();
    logic ok;
    logic bk;
    ok = ldn < 8'h08;
    bk = ok && (ldn == 8'h00 || ldn == 8'h03 || ldn == 8'h04 || ldn == 8'h05);
    case (idx)
      8'h07: return ldn;
      8'h22: return act_v;
      8'h24: return gcfg;
      8'h30: return ok ? {7'h00, act_v[ldn[2:0]]} : 8'h00;
      8'h60: return bk ? bas[ldn[2:0]][15:8] : 8'h00;
      8'h61: return bk ? bas[ldn[2:0]][7:0] : 8'h00;
      8'h70: return ok ? irq[ldn[2:0]] : 8'h00;
      8'h74: return (ldn == 8'h00 || ldn == 8'h03) ? dma[ldn[2:0]] : 8'h00;
      default: return 8'h00;
    endcase
  endfunction

  // Model update on a data port write
  task automatic cfg_wr(input logic [7:0] d);
    logic bk;
    bk = ldn == 8'h00 || ldn == 8'h03 || ldn == 8'h04 || ldn == 8'h05;
    case (idx)
      8'h07: ldn = d;
      8'h22: act_v = d;
      8'h24: gcfg = d;
      8'h30: if (ldn < 8'h08) act_v[ldn[2:0]] = d[0];
      8'h60: if (bk) bas[ldn[2:0]][15:8] = d;
      8'h61: if (bk) bas[ldn[2:0]][7:0] = d;
      8'h70: if (ldn < 8'h08) irq[ldn[2:0]] = d;
      8'h74: if (ldn == 8'h00 || ldn == 8'h03) dma[ldn[2:0]] = d;
      default: ;
    endcase
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // ****************************************
  // One bus cycle, model update and compare
  // ****************************************
  task automatic step(input logic wr, input logic rd,
                      input logic [15:0] a, input logic [7:0] d);
    logic [7:0] e;
    logic [7:0] r;
    logic       cp;
    logic       h;
    cp = a == LDIO_CFG_INDEX_PORT || a == LDIO_CFG_DATA_PORT;
    e = (wr || rd) ? dec(a) : 8'h00;
    h = e[7:3] != 5'h00;
    r = cfg_rd();
    if (wr && a == LDIO_CFG_DATA_PORT) cfg_wr(d);
    if (wr && a == LDIO_CFG_INDEX_PORT) idx = d;
    if (wr || rd) host.cycle(wr, rd, a, d);
    else host.idle();
    chk("sel", {3'h0, e[7:3]}, got_sel);
    chk("ustb", {6'h00, wr && h, rd && h}, {6'h00, unit_wr, unit_rd});
    if (h) chk("offset", {5'h00, e[2:0]}, {5'h00, unit_offset});
    if (h && wr) chk("wdata", d, unit_wdata);
    chk("rvalid", {7'h00, rd && cp}, {7'h00, cfg_rvalid});
    if (rd && cp) chk("rdata", a[0] ? r : idx, cfg_rdata);
    chk("on", act_v, device_on);
    for (int i = 0; i < 8; i++)
      chk("irq", irq[i] & 8'h0F, {4'h0, irq_sel_flat[4*i +: 4]});
    chk("fdma", dma[0] & 8'h07, {5'h00, floppy_dma_sel});
    chk("pdma", dma[3] & 8'h07, {5'h00, parallel_dma_sel});
  endtask

  task automatic wcfg(input logic [7:0] i, input logic [7:0] d);
    step(1'b1, 1'b0, LDIO_CFG_INDEX_PORT, i);
    step(1'b1, 1'b0, LDIO_CFG_DATA_PORT, d);
  endtask

  task automatic rcfg(input logic [7:0] i);
    step(1'b1, 1'b0, LDIO_CFG_INDEX_PORT, i);
    step(1'b0, 1'b1, LDIO_CFG_DATA_PORT, 8'h00);
  endtask

  // Program one device base and make it the only one on
  task automatic setdev(input int d, input logic [15:0] b);
    wcfg(LDIO_IDX_LDN, 8'(d));
    wcfg(LDIO_IDX_BASE_HI, b[15:8]);
    wcfg(LDIO_IDX_BASE_LO, b[7:0]);
    rcfg(LDIO_IDX_BASE_HI);
    wcfg(LDIO_IDX_PWR, 8'(1 << d));
  endtask

  // Back-to-back accesses from two below to nine above the base
  task automatic sweep(input logic [15:0] b);
    for (int k = -2; k < 10; k++) begin
      seed = lfsr(seed);
      step(k[0], ~k[0], b + 16'(k), seed[7:0]);
    end
  endtask

  task automatic do_reset();
    rst = 1'b1;
    act_v = 8'h00;
    ldn = 8'h00;
    idx = 8'h00;
    gcfg = 8'h00;
    foreach (bas[i]) begin
      bas[i] = 16'h0000;
      irq[i] = 8'h00;
      dma[i] = 8'h00;
    end
    irq[0] = LDIO_IRQ_RST_FLOPPY;
    dma[0] = LDIO_DMA_RST_FLOPPY;
    dma[3] = LDIO_DMA_RST_PARALLEL;
    repeat (6) host.idle();
    rst = 1'b0;
  endtask

  task automatic results();
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      results();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'h00008C90;
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    rst = 1'b1;
    do_reset();
    step(1'b0, 1'b0, 16'h0000, 8'h00);
    rcfg(LDIO_IDX_IRQ);
    foreach (tdev[i]) begin
      setdev(tdev[i], tbase[i]);
      sweep(tbase[i]);
    end
    wcfg(LDIO_IDX_PWR, 8'h80);
    foreach (kaddr[i])
      step(kaddr[i][0], ~kaddr[i][0], kaddr[i], 8'hA5);
    wcfg(LDIO_IDX_GCFG, 8'h40);
    step(1'b0, 1'b1, 16'h1064, 8'h00);
    setdev(4, 16'h02F8);
    step(1'b0, 1'b1, 16'h12F8, 8'h00);
    wcfg(LDIO_IDX_GCFG, 8'h00);
    step(1'b0, 1'b1, 16'h12F8, 8'h00);
    wcfg(LDIO_IDX_LDN, 8'h05);
    wcfg(LDIO_IDX_ACT, 8'h01);
    rcfg(LDIO_IDX_PWR);
    wcfg(LDIO_IDX_PWR, 8'h00);
    rcfg(LDIO_IDX_ACT);
    wcfg(LDIO_IDX_LDN, 8'h09);
    wcfg(LDIO_IDX_ACT, 8'h01);
    rcfg(LDIO_IDX_ACT);
    rcfg(8'h31);
    step(1'b0, 1'b1, LDIO_CFG_INDEX_PORT, 8'h00);
    for (int i = 0; i < LDIO_NUM_DEV; i++) begin
      seed = lfsr(seed);
      wcfg(LDIO_IDX_LDN, 8'(i));
      wcfg(LDIO_IDX_IRQ, {4'h0, seed[3:0]});
      wcfg(LDIO_IDX_DMA, {5'h00, seed[6:4]});
      rcfg(LDIO_IDX_DMA);
    end
    for (int n = 0; n < 40; n++) begin
      seed = lfsr(seed);
      setdev(order[seed[1:0]], {3'h0, seed[31] & seed[30], seed[11:2],
             2'h0} | 16'h0040);
      sweep(bas[order[seed[1:0]]]);
    end
    do_reset();
    step(1'b0, 1'b0, 16'h0000, 8'h00);
    rcfg(LDIO_IDX_DMA);
    results();
  end
endmodule // tb
`default_nettype wire
